// [hw/asf_device.sv]
// device end: apb registers, frame transmitter and frame receiver
`timescale 1ns/1ps
`default_nettype none
module asf_device
  import asf_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial line
  asf_line_if.device line
);
  logic [7:0] fmt_ff;
  logic [15:0] baud_ff;
  logic [31:0] prdata_ff;
  logic pready_ff, pslverr_ff;
  logic txd_ff;
  logic rxd_prev_ff;
  logic rx_s1_ff, rx_s2_ff, rx_s3_ff;
  logic [7:0] txsh_ff, rxsh_ff, rxdata_ff;
  logic tx_xbit_ff, rx_xbit_ff;
  logic rxvalid_ff, perr_ff, ferr_ff;
  asf_state_e tx_st_ff, rx_st_ff;
  logic [15:0] tx_cnt_ff, rx_cnt_ff;
  logic [2:0] tx_bit_ff, rx_bit_ff;
  logic rx_par_ff;

  // format decode; every framing option lives in one register
  wire [3:0] dbits = ASF_DATA_BITS_MIN + {2'h0, fmt_ff[ASF_FMT_DLEN_LO +: 2]};
  wire pe = fmt_ff[ASF_FMT_PE];
  wire [1:0] ptype = fmt_ff[ASF_FMT_PTYPE_LO +: 2];
  wire xbe = fmt_ff[ASF_FMT_XBE] & ~pe;
  wire stop2 = fmt_ff[ASF_FMT_STOP2] & (fmt_ff[ASF_FMT_DLEN_LO +: 2] != 2'h0);
  wire mce = fmt_ff[ASF_FMT_MCE];
  wire xslot = pe | xbe;
  wire [2:0] last_bit = 3'(dbits - 4'h1);
  wire [7:0] dmask = 8'(16'h00FF >> (4'h8 - dbits));

  // apb decode
  wire acc = psel & penable & ~pready_ff;
  // a write lands on the edge at which the master sees pready high
  wire xfer = psel & penable & pready_ff;
  wire wr = xfer & pwrite;
  wire hit_fmt = paddr == ASF_OFF_FORMAT;
  wire hit_tx = paddr == ASF_OFF_TXDATA;
  wire hit_rx = paddr == ASF_OFF_RXDATA;
  wire hit_st = paddr == ASF_OFF_STATUS;
  wire hit_bd = paddr == ASF_OFF_BAUD;
  wire mapped = hit_fmt | hit_tx | hit_rx | hit_st | hit_bd;
  wire tx_busy = tx_st_ff != ASF_IDLE;
  wire tx_go = wr & hit_tx & ~tx_busy;
  wire rd_rx = acc & ~pwrite & hit_rx;
  wire [31:0] status = {27'h0, rx_xbit_ff, ferr_ff, perr_ff, rxvalid_ff, tx_busy};
  wire [31:0] rsel = hit_fmt ? {24'h0, fmt_ff} : hit_tx ? 32'h0 :
                     hit_rx ? {24'h0, rxdata_ff} : hit_st ? status :
                     hit_bd ? {16'h0, baud_ff} : 32'h0;
  wire [15:0] bmax = (baud_ff == 16'h0) ? 16'h0 : 16'(baud_ff - 16'h1);
  wire [15:0] bhalf = {1'b0, bmax[15:1]};
  wire tx_tick = tx_cnt_ff == bmax;
  wire rx_tick = rx_cnt_ff == bmax;
  wire rxd = rx_s3_ff;
  // previous level resets high, so leaving reset never looks like a start edge
  wire rx_fall = (rx_s2_ff == rx_s3_ff) & ~rx_s2_ff & rxd_prev_ff;

  // apb slave answers one cycle after the access phase starts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0;
      fmt_ff <= ASF_FMT_RESET;
      baud_ff <= ASF_BAUD_RESET;
    end else begin
      pready_ff <= acc;
      pslverr_ff <= acc & ~mapped;
      prdata_ff <= (acc & ~pwrite) ? rsel : 32'h0;
      if (wr & hit_fmt) fmt_ff <= pwdata[7:0];
      if (wr & hit_bd) baud_ff <= pwdata[15:0];
    end
  end
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;

  // transmitter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_st_ff <= ASF_IDLE;
      txd_ff <= 1'b1;
      tx_cnt_ff <= 16'h0;
      tx_bit_ff <= 3'h0;
      txsh_ff <= 8'h0;
      tx_xbit_ff <= 1'b0;
    end else begin
      tx_cnt_ff <= (tx_go | tx_tick) ? 16'h0 : 16'(tx_cnt_ff + 16'h1);
      case (tx_st_ff)
        ASF_IDLE: begin
          txd_ff <= 1'b1;
          if (tx_go) begin
            txsh_ff <= pwdata[7:0] & dmask;
            // extra bit from bit 8; parity type picks computed bit
            tx_xbit_ff <= pe ? asf_parity(pwdata[7:0] & dmask, ptype) : pwdata[8];
            txd_ff <= 1'b0;
            tx_st_ff <= ASF_START;
          end
        end
        ASF_START: if (tx_tick) begin
          txd_ff <= txsh_ff[0];
          txsh_ff <= {1'b0, txsh_ff[7:1]};
          tx_bit_ff <= 3'h0;
          tx_st_ff <= ASF_DATA;
        end
        ASF_DATA: if (tx_tick) begin
          if (tx_bit_ff == last_bit) begin
            txd_ff <= xslot ? tx_xbit_ff : 1'b1;
            tx_st_ff <= xslot ? ASF_XBIT : ASF_STOP1;
          end else begin
            txd_ff <= txsh_ff[0];
            txsh_ff <= {1'b0, txsh_ff[7:1]};
            tx_bit_ff <= 3'(tx_bit_ff + 3'h1);
          end
        end
        ASF_XBIT: if (tx_tick) begin
          txd_ff <= 1'b1;
          tx_st_ff <= ASF_STOP1;
        end
        ASF_STOP1: if (tx_tick) begin
          tx_st_ff <= stop2 ? ASF_STOP2 : ASF_IDLE;
        end
        default: if (tx_tick) begin
          tx_st_ff <= ASF_IDLE;
        end
      endcase
    end
  end
  assign line.dev_txd = txd_ff;

  // rx pin synchroniser; change counts once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_s1_ff <= 1'b1;
      rx_s2_ff <= 1'b1;
      rx_s3_ff <= 1'b1;
      rxd_prev_ff <= 1'b1;
    end else begin
      rx_s1_ff <= line.rem_txd;
      rx_s2_ff <= rx_s1_ff;
      rx_s3_ff <= rx_s2_ff;
      rxd_prev_ff <= rx_s3_ff;
    end
  end

  // receiver samples mid-bit; parity and stop checked in hardware
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_st_ff <= ASF_IDLE;
      rx_cnt_ff <= 16'h0;
      rx_bit_ff <= 3'h0;
      rxsh_ff <= 8'h0;
      rxdata_ff <= 8'h0;
      rx_xbit_ff <= 1'b0;
      rx_par_ff <= 1'b0;
      rxvalid_ff <= 1'b0;
      perr_ff <= 1'b0;
      ferr_ff <= 1'b0;
    end else begin
      rx_cnt_ff <= (rx_tick || rx_st_ff == ASF_IDLE) ? 16'h0 : 16'(rx_cnt_ff + 16'h1);
      if (rd_rx) begin
        rxvalid_ff <= 1'b0;
        perr_ff <= 1'b0;
        ferr_ff <= 1'b0;
      end
      case (rx_st_ff)
        ASF_IDLE: if (rx_fall) begin
          rx_st_ff <= ASF_START;
        end
        ASF_START: if (rx_cnt_ff == bhalf) begin
          rx_st_ff <= rxd ? ASF_IDLE : ASF_DATA; // glitch rejected
          rx_bit_ff <= 3'h0;
          rxsh_ff <= 8'h0;
        end
        ASF_DATA: if (rx_cnt_ff == bhalf) begin
          rxsh_ff[rx_bit_ff] <= rxd;
          rx_bit_ff <= 3'(rx_bit_ff + 3'h1);
          if (rx_bit_ff == last_bit) rx_st_ff <= xslot ? ASF_XBIT : ASF_STOP1;
        end
        ASF_XBIT: if (rx_cnt_ff == bhalf) begin
          rx_par_ff <= rxd;
          rx_st_ff <= ASF_STOP1;
        end
        default: if (rx_cnt_ff == bhalf) begin
          rx_st_ff <= ASF_IDLE;
          // in multiprocessor mode only frames with extra bit set are kept
          if (!mce || (xslot && rx_par_ff)) begin
            rxdata_ff <= rxsh_ff;
            rx_xbit_ff <= rx_par_ff;
            rxvalid_ff <= 1'b1; // set wins over read clear
            perr_ff <= pe & (rx_par_ff != asf_parity(rxsh_ff, ptype));
            ferr_ff <= ~rxd;
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// [hw/asf_pkg.sv]
// package of constants for the async serial frame format block
package asf_pkg;
  // apb register offsets (byte addresses)
  localparam logic [7:0] ASF_OFF_FORMAT = 8'h00;
  localparam logic [7:0] ASF_OFF_TXDATA = 8'h04;
  localparam logic [7:0] ASF_OFF_RXDATA = 8'h08;
  localparam logic [7:0] ASF_OFF_STATUS = 8'h0C;
  localparam logic [7:0] ASF_OFF_BAUD = 8'h10;
  // frame_format_register field positions
  localparam int ASF_FMT_MCE = 7;
  localparam int ASF_FMT_PTYPE_LO = 5;
  localparam int ASF_FMT_PE = 4;
  localparam int ASF_FMT_DLEN_LO = 2;
  localparam int ASF_FMT_XBE = 1;
  localparam int ASF_FMT_STOP2 = 0;
  localparam logic [7:0] ASF_FMT_RESET = 8'h0C;
  // status bit positions
  localparam int ASF_ST_TXBUSY = 0;
  localparam int ASF_ST_RXVALID = 1;
  localparam int ASF_ST_PERR = 2;
  localparam int ASF_ST_FERR = 3;
  localparam int ASF_ST_RXXBIT = 4;
  // parity types
  localparam logic [1:0] ASF_PAR_ODD = 2'h0;
  localparam logic [1:0] ASF_PAR_EVEN = 2'h1;
  localparam logic [1:0] ASF_PAR_MARK = 2'h2;
  localparam logic [1:0] ASF_PAR_SPACE = 2'h3;
  // bit period divider, cycles of pclk per bit
  localparam logic [15:0] ASF_BAUD_RESET = 16'h01B2;
  localparam logic [3:0] ASF_DATA_BITS_MIN = 4'h5;
  typedef enum logic [2:0] {ASF_IDLE, ASF_START, ASF_DATA, ASF_XBIT, ASF_STOP1, ASF_STOP2}
    asf_state_e;
  // parity bit from the already masked data and the parity type
  function automatic logic asf_parity(input logic [7:0] d, input logic [1:0] ty);
    logic p;
    p = ^d;
    if (ty == ASF_PAR_MARK) begin
      asf_parity = 1'b1;
    end else if (ty == ASF_PAR_SPACE) begin
      asf_parity = 1'b0;
    end else if (ty == ASF_PAR_EVEN) begin
      asf_parity = p;
    end else begin
      asf_parity = ~p;
    end
  endfunction
endpackage

// [hw/asf_line_if.sv]
// serial line between the device end and the remote transceiver end
`timescale 1ns/1ps
`default_nettype none
interface asf_line_if;
  logic dev_txd;
  logic rem_txd;
  modport device (output dev_txd, input rem_txd);
  modport remote (input dev_txd, output rem_txd);
endinterface
`default_nettype wire

// [hw/asf_remote.sv]
// remote end: simple transceiver driven by user strobes
`timescale 1ns/1ps
`default_nettype none
module asf_remote
  import asf_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // user format and bit period
  input wire logic [7:0] fmt,
  input wire logic [15:0] bit_cycles,
  // user transmit
  input wire logic tx_start,
  input wire logic [8:0] tx_word,
  output logic tx_busy,
  // user receive
  output logic rx_done,
  output logic [8:0] rx_word,
  // serial line
  asf_line_if.remote line
);
  logic busy_ff, done_ff, txd_ff;
  logic [11:0] sh_ff, rsh_ff;
  logic [3:0] left_ff, rleft_ff;
  logic [15:0] cnt_ff, rcnt_ff;
  logic r1_ff, r2_ff, r3_ff, rbusy_ff;
  logic [8:0] rw_ff;
  wire [3:0] db = ASF_DATA_BITS_MIN + {2'h0, fmt[ASF_FMT_DLEN_LO +: 2]};
  wire xs = fmt[ASF_FMT_PE] | fmt[ASF_FMT_XBE];
  wire s2 = fmt[ASF_FMT_STOP2] & (fmt[ASF_FMT_DLEN_LO +: 2] != 2'h0);
  wire [7:0] dm = 8'(16'h00FF >> (4'h8 - db));
  wire xb = fmt[ASF_FMT_PE] ? asf_parity(tx_word[7:0] & dm, fmt[ASF_FMT_PTYPE_LO +: 2])
            : tx_word[8];
  wire [3:0] nbits = 4'(db + {3'h0, xs} + {3'h0, s2} + 4'h2);
  wire [11:0] frame = ({4'h0, tx_word[7:0] & dm} | ({11'h0, xb} << db) | (12'hFFF << (db +
                      {3'h0, xs}))) << 1;
  wire tick = cnt_ff == 16'(bit_cycles - 16'h1);
  wire rtick = rcnt_ff == 16'(bit_cycles - 16'h1);
  wire rmid = rcnt_ff == {1'b0, bit_cycles[15:1]};
  wire [3:0] rbits = 4'(db + {3'h0, xs} + 4'h1);

  // transmitter shifts the prebuilt frame out LSB first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_ff <= 1'b0;
      txd_ff <= 1'b1;
      sh_ff <= 12'hFFF;
      left_ff <= 4'h0;
      cnt_ff <= 16'h0;
    end else if (!busy_ff) begin
      txd_ff <= 1'b1;
      cnt_ff <= 16'h0;
      if (tx_start) begin
        busy_ff <= 1'b1;
        txd_ff <= frame[0];
        sh_ff <= {1'b1, frame[11:1]};
        left_ff <= 4'(nbits - 4'h1);
      end
    end else begin
      cnt_ff <= tick ? 16'h0 : 16'(cnt_ff + 16'h1);
      if (tick) begin
        if (left_ff == 4'h0) begin
          busy_ff <= 1'b0;
        end else begin
          txd_ff <= sh_ff[0];
          sh_ff <= {1'b1, sh_ff[11:1]};
          left_ff <= 4'(left_ff - 4'h1);
        end
      end
    end
  end

  // receiver: three-stage sync, mid-bit sampling
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r1_ff <= 1'b1;
      r2_ff <= 1'b1;
      r3_ff <= 1'b1;
      rbusy_ff <= 1'b0;
      rsh_ff <= 12'h0;
      rleft_ff <= 4'h0;
      rcnt_ff <= 16'h0;
      done_ff <= 1'b0;
      rw_ff <= 9'h0;
    end else begin
      r1_ff <= line.dev_txd;
      r2_ff <= r1_ff;
      r3_ff <= r2_ff;
      done_ff <= 1'b0;
      if (!rbusy_ff) begin
        rcnt_ff <= 16'h0;
        if (!r2_ff && !r3_ff) begin
          rbusy_ff <= 1'b1;
          rleft_ff <= rbits;
          rcnt_ff <= 16'h1;
        end
      end else begin
        rcnt_ff <= rtick ? 16'h0 : 16'(rcnt_ff + 16'h1);
        if (rmid) begin
          rsh_ff <= {r3_ff, rsh_ff[11:1]};
          if (rleft_ff == 4'h0) begin
            rbusy_ff <= 1'b0;
            done_ff <= 1'b1;
            // start bit dropped: data from bit 0, extra bit at bit db
            rw_ff <= 9'(rsh_ff >> (4'hD - rbits));
          end else begin
            rleft_ff <= 4'(rleft_ff - 4'h1);
          end
        end
      end
    end
  end
  assign line.rem_txd = txd_ff;
  assign tx_busy = busy_ff;
  assign rx_done = done_ff;
  assign rx_word = rw_ff;
endmodule
`default_nettype wire

// [verif/asf_line_assertions.sv]
// checker: bit timing and idle level on both serial lines
`timescale 1ns/1ps
`default_nettype none
module asf_line_assertions #(
  parameter int BIT = 8
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // serial line
  input wire logic dev_txd,
  input wire logic rem_txd
);
  logic [15:0] dlo_ff;
  logic [15:0] dhi_ff;
  logic [15:0] rlo_ff;
  logic [15:0] rhi_ff;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // level run lengths; high runs saturate so a long idle never wraps
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dlo_ff <= 16'h0000;
      dhi_ff <= 16'h0000;
      rlo_ff <= 16'h0000;
      rhi_ff <= 16'h0000;
    end else begin
      dlo_ff <= dev_txd ? 16'h0000 : dlo_ff + 16'h0001;
      dhi_ff <= !dev_txd ? 16'h0000 : dhi_ff + 16'(dhi_ff != 16'hFFFF);
      rlo_ff <= rem_txd ? 16'h0000 : rlo_ff + 16'h0001;
      rhi_ff <= !rem_txd ? 16'h0000 : rhi_ff + 16'(rhi_ff != 16'hFFFF);
    end
  end
  a_dev_idle_high: assert property ($rose(presetn) |-> dev_txd)
    else $error("device line not high after reset");
  a_rem_idle_high: assert property ($rose(presetn) |-> rem_txd)
    else $error("remote line not high after reset");
  a_dev_start_full: assert property ($fell(dev_txd) |-> !dev_txd [*8])
    else $error("device low bit shorter than a bit period");
  a_rem_start_full: assert property ($fell(rem_txd) |-> !rem_txd [*8])
    else $error("remote low bit shorter than a bit period");
  a_dev_low_whole: assert property ($rose(dev_txd) |->
    dlo_ff % BIT == 0 && dlo_ff <= 16'(10 * BIT))
    else $error("device low run not whole bits");
  a_rem_low_whole: assert property ($rose(rem_txd) |->
    rlo_ff % BIT == 0 && rlo_ff <= 16'(10 * BIT))
    else $error("remote low run not whole bits");
  a_dev_high_min: assert property ($fell(dev_txd) |-> dhi_ff >= 16'(BIT))
    else $error("device high run shorter than a bit");
  a_rem_high_min: assert property ($fell(rem_txd) |-> rhi_ff >= 16'(BIT))
    else $error("remote high run shorter than a bit");
endmodule
`default_nettype wire

// [verif/test_async_serial_frame_format.sv]
// bench: device and remote ends joined by one serial line
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin miscompares++; \
  $display("mismatch %s exp %h got %h", n, e, s); end end
module test_async_serial_frame_format
  import asf_pkg::*;
();
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, slv, rx_seen;
  logic [7:0] paddr = 8'h00, fmt = 8'h0C;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, tx_start = 0, tx_busy, rx_done;
  logic [8:0] tx_word = 9'h000, rx_word, rx_last;
  int miscompares = 0, n_tests = 0;
  asf_line_if line_if ();
  asf_device i_asf_device (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .line(line_if.device));
  asf_remote i_asf_remote (.pclk(pclk), .presetn(presetn), .fmt(fmt), .bit_cycles(16'h0008),
    .tx_start(tx_start), .tx_word(tx_word), .tx_busy(tx_busy), .rx_done(rx_done),
    .rx_word(rx_word), .line(line_if.remote));
  asf_line_assertions #(.BIT(8)) i_chk (.pclk(pclk), .presetn(presetn),
    .dev_txd(line_if.dev_txd), .rem_txd(line_if.rem_txd));
  always #10 pclk = ~pclk;
  // one-cycle receive pulse is caught here, the main flow may be busy sampling
  always @(posedge pclk) begin
    if (rx_done === 1'b1) begin
      rx_seen = 1'b1;
      rx_last = rx_word;
    end
  end
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no cycle count assumed; only the watchdog ends a hung wait
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // bit after the data: parity from data and type, else the extra bit
  function automatic logic xbit(input logic [7:0] f, input logic [7:0] d, input logic x);
    if (!f[4]) return x;
    case (f[6:5])
      ASF_PAR_MARK: return 1'b1;
      ASF_PAR_SPACE: return 1'b0;
      ASF_PAR_EVEN: return ^d;
      default: return ~^d;
    endcase
  endfunction
  // device sends a frame, then remote sends one back
  task automatic one(input logic [7:0] f, input logic flip);
    logic [7:0] d, rf, dm;
    logic x, b, rb, kept, has;
    logic [11:0] ef, gf;
    logic [8:0] ew;
    logic [4:0] es, sm;
    int db, nb, t;
    db = f[3:2] + 5;
    has = f[4] | f[1];
    dm = 8'((9'h001 << db) - 9'h001);
    d = 8'($urandom) & dm;
    x = 1'($urandom);
    b = xbit(f, d, x);
    nb = 2 + db + has + (f[0] && db > 5);
    ef = (12'hFFF << (db + 1)) | {3'h0, d, 1'b0};
    if (has) ef[db + 1] = b;
    rx_seen = 1'b0;
    apb(1'b1, ASF_OFF_FORMAT, {24'h0, f});
    fmt <= f & 8'h7F;
    apb(1'b1, ASF_OFF_TXDATA, {23'h0, x, d});
    t = 0;
    while (line_if.dev_txd !== 1'b0 && t++ < 50) @(posedge pclk);
    `CHK("start_bit", 1'b0, line_if.dev_txd);
    repeat (4) @(posedge pclk);
    for (int i = 0; i < 12; i++) begin
      gf[i] = line_if.dev_txd;
      repeat (8) @(posedge pclk);
    end
    `CHK("line_frame", ef, gf);
    repeat (16) @(posedge pclk);
    `CHK("rx_done", 1'b1, rx_seen);
    // no bit after the data unless parity or extra bit is on
    ew = {1'b0, d} | (9'(has & b) << db);
    `CHK("rx_word", ew, rx_last & 9'((10'h002 << db) - 10'h001));
    // ptype bit 5 flips odd/even and mark/space, so parity must mismatch
    rf = (f & 8'h7F) ^ ((flip && f[4]) ? 8'h20 : 8'h00);
    rb = xbit(rf, d, x);
    kept = !f[7] || rb;
    @(posedge pclk);
    fmt <= rf;
    tx_word <= {x, d};
    tx_start <= 1'b1;
    @(posedge pclk);
    tx_start <= 1'b0;
    t = 0;
    @(posedge pclk);
    while (tx_busy === 1'b1 && t < 200) begin
      t++;
      @(posedge pclk);
    end
    `CHK("tx_len", nb * 8, t);
    repeat (8) @(posedge pclk);
    apb(1'b0, ASF_OFF_STATUS, 32'h0);
    sm = {has & kept, 4'hF};
    es = {rb, 1'b0, flip & f[4], kept, 1'b0} & sm;
    `CHK("status", es, rd[4:0] & sm);
    if (kept) begin
      apb(1'b0, ASF_OFF_RXDATA, 32'h0);
      `CHK("rxdata", d, rd[7:0] & dm);
    end
  endtask
  initial begin
    repeat (40000) @(posedge pclk);
    miscompares++;
    finish_test();
  end
  initial begin
    logic [7:0] f;
    void'($urandom(32'hdbb9));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ASF_OFF_FORMAT, 32'h0);
    `CHK("fmt_reset", ASF_FMT_RESET, rd[7:0]);
    `CHK("slverr_mapped", 1'b0, slv);
    apb(1'b0, ASF_OFF_BAUD, 32'h0);
    `CHK("baud_reset", ASF_BAUD_RESET, rd[15:0]);
    apb(1'b0, 8'h14, 32'h0);
    `CHK("unmapped", 1'b1, slv);
    apb(1'b1, ASF_OFF_BAUD, 32'h8);
    // first every length, parity type and stop pairing, then random formats
    for (int i = 0; i < 48; i++) begin
      f = (i < 32) ? {1'b0, 2'(i), i[2], 2'(i >> 3), i[1], i[0]} : 8'($urandom);
      if (!(f[4] | f[1])) f[7] = 1'b0;
      one(f, !f[7] && 1'($urandom));
    end
    finish_test();
  end
endmodule
`default_nettype wire
